// [common/gio_pkg.sv]
/*
  Shared constants and carrier types for the five-port GPIO block.
  Assumes a 32-bit APB slave interface on a single 250 MHz clock.
*/
package gio_pkg;

  // ==========================================================================
  // Port geometry
  // ==========================================================================
  localparam int unsigned NUM_PORTS  = 5;   // Ports A, B, C, D, G
  localparam int unsigned PORT_W     = 8;   // Register width per port
  localparam int unsigned PORT_G_W   = 1;   // Port G has one pin (33 lines total)
  localparam int unsigned PIDX_A     = 0;
  localparam int unsigned PIDX_B     = 1;
  localparam int unsigned PIDX_C     = 2;
  localparam int unsigned PIDX_D     = 3;
  localparam int unsigned PIDX_G     = 4;

  // Shared pin bit positions
  localparam int unsigned BZ_BIT     = 0;   // Buzzer on port B bit 0
  localparam int unsigned BZN_BIT    = 1;   // Inverted buzzer on port B bit 1
  localparam int unsigned EXTI_BIT   = 0;   // External interrupt on port G bit 0
  localparam int unsigned T0_BIT     = 0;   // Timer 0 input on port C bit 0
  localparam int unsigned T1_BIT     = 5;   // Timer 1 input on port C bit 5

  // ==========================================================================
  // Register map (byte addresses)
  // ==========================================================================
  localparam logic [7:0] OFS_DATA_A  = 8'h00;
  localparam logic [7:0] OFS_DATA_B  = 8'h04;
  localparam logic [7:0] OFS_DATA_C  = 8'h08;
  localparam logic [7:0] OFS_DATA_D  = 8'h0c;
  localparam logic [7:0] OFS_DATA_G  = 8'h10;
  localparam logic [7:0] OFS_DIR_A   = 8'h14;
  localparam logic [7:0] OFS_DIR_B   = 8'h18;
  localparam logic [7:0] OFS_DIR_C   = 8'h1c;
  localparam logic [7:0] OFS_DIR_D   = 8'h20;
  localparam logic [7:0] OFS_DIR_G   = 8'h24;
  localparam logic [7:0] OFS_WAKE_EN = 8'h28;  // Per-pin port A wake enable
  localparam logic [7:0] OFS_HALT    = 8'h2c;  // Write bit 0 = 1 to halt; read halted
  localparam logic [7:0] OFS_IRQ_ST  = 8'h30;  // Sticky events, write one to clear
  localparam logic [7:0] OFS_IRQ_MSK = 8'h34;  // Interrupt mask, 1 = enabled
  localparam logic [7:0] OFS_BITOP   = 8'h38;  // Bit set/clear request

  // Bit operation register fields
  localparam int unsigned BOP_BIT_LSB  = 0;  // Bit index [2:0]
  localparam int unsigned BOP_BIT_MSB  = 2;
  localparam int unsigned BOP_PORT_LSB = 4;  // Port index [6:4]
  localparam int unsigned BOP_PORT_MSB = 6;
  localparam int unsigned BOP_DIR_POS  = 7;  // 1 = direction register, 0 = data
  localparam int unsigned BOP_VAL_POS  = 8;  // New bit value

  // Interrupt status bits
  localparam int unsigned IRQ_W      = 2;
  localparam int unsigned IRQ_WAKE   = 0;   // A wake-up edge was seen
  localparam int unsigned IRQ_EXTI   = 1;   // External interrupt falling edge

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] RST_PORT    = 8'hff;  // Data and direction: all inputs
  localparam logic [7:0] RST_ZERO8   = 8'h00;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;

  // Timer pin modes as seen from the timer control
  typedef enum logic [1:0] {
    GIO_TM_OFF   = 2'b00,
    GIO_TM_TIMER = 2'b01,
    GIO_TM_EVENT = 2'b10,
    GIO_TM_PWM   = 2'b11
  } gio_tmode_e;

  // Fixed configuration options
  typedef struct packed {
    logic [NUM_PORTS-1:0] pull_en;   // Per-port pull-high option
    logic                 buzzer_en; // Buzzer function option
  } gio_cfg_s;

  // Pin bundle for one 8-bit port
  typedef struct packed {
    logic [PORT_W-1:0] o;    // Output value
    logic [PORT_W-1:0] oe;   // Output enable, high while driving
    logic [PORT_W-1:0] pu;   // Weak pull-high enable
  } gio_pin_s;

endpackage

// [design/gio_wake.sv]
/*
  Port A wake-up edge detector.
  Assumes pin levels synchronous to clk_sys; halt tracking is done by the caller.
*/
`timescale 1ns/1ps
`default_nettype none

module gio_wake (
  input  wire logic                     clk_sys,
  input  wire logic                     rst,
  input  wire logic [gio_pkg::PORT_W-1:0] pin_level,
  input  wire logic [gio_pkg::PORT_W-1:0] wake_en,
  output logic                          wake_evt
);

  // ==========================================================================
  // Previous sample per pin
  // ==========================================================================
  logic [gio_pkg::PORT_W-1:0] prev_r;    // Last sampled level
  logic [gio_pkg::PORT_W-1:0] prev_nxt;
  logic [gio_pkg::PORT_W-1:0] fall;      // Per-pin 1 then 0

  // Next sample and per-pin falling edge
  always_comb begin
    prev_nxt = pin_level;
    fall     = prev_r & ~pin_level & wake_en;
  end

  // Sample register, idle high so reset does not fake an edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prev_r <= gio_pkg::RST_PORT;
    end else begin
      prev_r <= prev_nxt;
    end
  end

  // Any enabled pin ends the halt
  assign wake_evt = |fall;

endmodule

`default_nettype wire

// [design/gio_top.sv]
/*
  Five-port bidirectional GPIO block with port A wake-up and shared pins.
  Assumes an APB master on clk_sys, pins synchronous to clk_sys, and
  timer and interrupt controllers outside that report their modes here.
*/
// Summary of operation
// - Thirty-three lines in five register-mapped ports.
// - Inputs read live, not latched.
// - Output latch holds until rewritten.
// - Pull-high per whole port, inputs only.
// - Direction bit governs same-position pin.
// - Direction one: driver off, read pin.
// - Direction zero: drive output latch.
// - Output pin reads back latch value.
// - Halt ends on enabled port A fall.
// - Wake enable per port A pin.
// - Buzzer on port B 0/1 when outputs.
// - Port G bit 0 feeds external interrupt.
// - Timer pin input in event/PWM, input dir.
// - Timer pin plain I/O when off/timer.
// - Reset sets data and direction to ones.
// - Bit set/clear is read-modify-write.
`timescale 1ns/1ps
`default_nettype none

module gio_top (
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic [31:0]               prdata,
  output logic                      pready,
  output logic                      pslverr,
  // Fixed configuration options
  input  wire gio_pkg::gio_cfg_s    cfg,
  // Pins, one bundle per port (port G uses bit 0 only)
  input  wire logic [gio_pkg::NUM_PORTS*gio_pkg::PORT_W-1:0] pin_in,
  output gio_pkg::gio_pin_s [gio_pkg::NUM_PORTS-1:0] pins,
  // Shared functions
  input  wire logic                 buzzer_out,
  input  wire logic                 exti_en,
  input  wire gio_pkg::gio_tmode_e  tmode0,
  input  wire gio_pkg::gio_tmode_e  tmode1,
  output logic                      exti_n,
  output logic                      timer0_ext_input,
  output logic                      timer1_ext_input,
  // Core status
  output logic                      halted,
  output logic                      irq
);

  localparam int unsigned W = gio_pkg::PORT_W;
  localparam int unsigned N = gio_pkg::NUM_PORTS;

  // ==========================================================================
  // State
  // ==========================================================================
  logic [N-1:0][W-1:0] data_r, data_nxt;    // Output latches
  logic [N-1:0][W-1:0] dir_r,  dir_nxt;     // Direction, 1 = input
  logic [W-1:0]        wake_en_r, wake_en_nxt; // Port A wake enable
  logic                halt_r, halt_nxt;    // Core halted
  logic [gio_pkg::IRQ_W-1:0] st_r, st_nxt;  // Sticky events
  logic [gio_pkg::IRQ_W-1:0] msk_r, msk_nxt; // Interrupt mask
  logic                exti_prev_r, exti_prev_nxt; // Last ext interrupt level
  logic [31:0]         prdata_r, prdata_nxt; // Registered read data

  logic [N-1:0][W-1:0] port_rd;     // Read view per port
  logic [N-1:0][W-1:0] pin_v;       // Pin levels per port
  logic [N-1:0][W-1:0] valid_m;     // Existing pins per port
  logic                wake_evt;    // Port A wake edge
  logic                exti_fall;   // External interrupt edge
  logic                wr_acc;      // APB write access cycle
  logic                rd_acc;      // APB read setup cycle
  logic                hit;         // Address is mapped

  // ==========================================================================
  // Pin view, read mux and drivers, one port per loop pass
  // ==========================================================================
  genvar gp;
  generate
    for (gp = 0; gp < N; gp++) begin : g_port
      // Port G has a single pin; its other bits do not exist
      assign valid_m[gp] = (gp == gio_pkg::PIDX_G) ? W'((1 << gio_pkg::PORT_G_W) - 1)
                                                   : {W{1'b1}};
      assign pin_v[gp]   = pin_in[gp*W +: W] & valid_m[gp];
      // Input bits read the pin, output bits read the latch
      assign port_rd[gp] = ((dir_r[gp] & pin_v[gp]) | (~dir_r[gp] & data_r[gp]))
                           & valid_m[gp];

      // Driver and pull-high control
      always_comb begin
        pins[gp].oe = ~dir_r[gp] & valid_m[gp];
        pins[gp].o  = data_r[gp] & valid_m[gp];
        pins[gp].pu = {W{cfg.pull_en[gp]}} & dir_r[gp] & valid_m[gp];
        if (gp == gio_pkg::PIDX_B && cfg.buzzer_en) begin
          // Buzzer replaces the latch on bits 0 and 1 in either direction; only oe limits it to output pins
          pins[gp].o[gio_pkg::BZ_BIT]  = buzzer_out;
          pins[gp].o[gio_pkg::BZN_BIT] = ~buzzer_out;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Shared inputs
  // ==========================================================================
  // External interrupt follows port G bit 0 only while enabled
  assign exti_n = exti_en ? pin_v[gio_pkg::PIDX_G][gio_pkg::EXTI_BIT] : 1'b1;

  // Timer inputs pass only in event or pulse-width mode with input direction
  assign timer0_ext_input = ((tmode0 == gio_pkg::GIO_TM_EVENT) || (tmode0 == gio_pkg::GIO_TM_PWM))
                            && dir_r[gio_pkg::PIDX_C][gio_pkg::T0_BIT]
                            && pin_v[gio_pkg::PIDX_C][gio_pkg::T0_BIT];
  assign timer1_ext_input = ((tmode1 == gio_pkg::GIO_TM_EVENT) || (tmode1 == gio_pkg::GIO_TM_PWM))
                            && dir_r[gio_pkg::PIDX_C][gio_pkg::T1_BIT]
                            && pin_v[gio_pkg::PIDX_C][gio_pkg::T1_BIT];

  assign exti_fall = exti_prev_r & ~exti_n;

  // ==========================================================================
  // Wake-up detector
  // ==========================================================================
  gio_wake u_wake (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .pin_level (pin_v[gio_pkg::PIDX_A]),
    .wake_en   (wake_en_r),
    .wake_evt  (wake_evt)
  );

  // ==========================================================================
  // APB decode
  // ==========================================================================
  assign wr_acc  = psel & penable & pwrite;
  assign rd_acc  = psel & ~penable & ~pwrite;   // Read data captured at setup
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_r;

  // Address hit check
  always_comb begin
    unique case (paddr)
      gio_pkg::OFS_DATA_A, gio_pkg::OFS_DATA_B, gio_pkg::OFS_DATA_C,
      gio_pkg::OFS_DATA_D, gio_pkg::OFS_DATA_G, gio_pkg::OFS_DIR_A,
      gio_pkg::OFS_DIR_B,  gio_pkg::OFS_DIR_C,  gio_pkg::OFS_DIR_D,
      gio_pkg::OFS_DIR_G,  gio_pkg::OFS_WAKE_EN, gio_pkg::OFS_HALT,
      gio_pkg::OFS_IRQ_ST, gio_pkg::OFS_IRQ_MSK, gio_pkg::OFS_BITOP: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // ==========================================================================
  // Register next-state logic
  // ==========================================================================
  always_comb begin
    logic [2:0] bop_port;
    logic [2:0] bop_bit;
    logic [W-1:0] rmw;
    bop_port      = pwdata[gio_pkg::BOP_PORT_MSB:gio_pkg::BOP_PORT_LSB];
    bop_bit       = pwdata[gio_pkg::BOP_BIT_MSB:gio_pkg::BOP_BIT_LSB];
    rmw           = gio_pkg::RST_ZERO8;
    data_nxt      = data_r;      // Latches hold until written
    dir_nxt       = dir_r;
    wake_en_nxt   = wake_en_r;
    halt_nxt      = halt_r;
    msk_nxt       = msk_r;
    st_nxt        = st_r;
    exti_prev_nxt = exti_n;
    prdata_nxt    = prdata_r;

    // Port A fall while halted resumes the core
    if (halt_r && wake_evt) begin
      halt_nxt = 1'b0;
    end

    if (wr_acc) begin
      unique case (paddr)
        gio_pkg::OFS_DATA_A:  data_nxt[gio_pkg::PIDX_A] = pwdata[W-1:0];
        gio_pkg::OFS_DATA_B:  data_nxt[gio_pkg::PIDX_B] = pwdata[W-1:0];
        gio_pkg::OFS_DATA_C:  data_nxt[gio_pkg::PIDX_C] = pwdata[W-1:0];
        gio_pkg::OFS_DATA_D:  data_nxt[gio_pkg::PIDX_D] = pwdata[W-1:0];
        gio_pkg::OFS_DATA_G:  data_nxt[gio_pkg::PIDX_G] = pwdata[W-1:0] | ~valid_m[gio_pkg::PIDX_G];
        gio_pkg::OFS_DIR_A:   dir_nxt[gio_pkg::PIDX_A]  = pwdata[W-1:0];
        gio_pkg::OFS_DIR_B:   dir_nxt[gio_pkg::PIDX_B]  = pwdata[W-1:0];
        gio_pkg::OFS_DIR_C:   dir_nxt[gio_pkg::PIDX_C]  = pwdata[W-1:0];
        gio_pkg::OFS_DIR_D:   dir_nxt[gio_pkg::PIDX_D]  = pwdata[W-1:0];
        gio_pkg::OFS_DIR_G:   dir_nxt[gio_pkg::PIDX_G]  = pwdata[W-1:0] | ~valid_m[gio_pkg::PIDX_G];
        gio_pkg::OFS_WAKE_EN: wake_en_nxt = pwdata[W-1:0];
        gio_pkg::OFS_HALT: begin
          if (pwdata[0]) begin
            halt_nxt = 1'b1;
          end
        end
        gio_pkg::OFS_IRQ_ST:  st_nxt  = st_r & ~pwdata[gio_pkg::IRQ_W-1:0];
        gio_pkg::OFS_IRQ_MSK: msk_nxt = pwdata[gio_pkg::IRQ_W-1:0];
        gio_pkg::OFS_BITOP: begin
          if (bop_port < 3'(N)) begin
            // Whole-port read, one bit changed, whole port written back
            rmw = pwdata[gio_pkg::BOP_DIR_POS] ? dir_r[bop_port] : port_rd[bop_port];
            rmw[bop_bit] = pwdata[gio_pkg::BOP_VAL_POS];
            if (pwdata[gio_pkg::BOP_DIR_POS]) begin
              dir_nxt[bop_port]  = rmw | ~valid_m[bop_port];
            end else begin
              data_nxt[bop_port] = rmw | ~valid_m[bop_port];
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Hardware set wins over a same-cycle clear
    if (wake_evt) begin
      st_nxt[gio_pkg::IRQ_WAKE] = 1'b1;
    end
    if (exti_fall) begin
      st_nxt[gio_pkg::IRQ_EXTI] = 1'b1;
    end

    // Read data captured in setup phase
    if (rd_acc) begin
      prdata_nxt = gio_pkg::RD_ZERO;
      unique case (paddr)
        gio_pkg::OFS_DATA_A:  prdata_nxt[W-1:0] = port_rd[gio_pkg::PIDX_A];
        gio_pkg::OFS_DATA_B:  prdata_nxt[W-1:0] = port_rd[gio_pkg::PIDX_B];
        gio_pkg::OFS_DATA_C:  prdata_nxt[W-1:0] = port_rd[gio_pkg::PIDX_C];
        gio_pkg::OFS_DATA_D:  prdata_nxt[W-1:0] = port_rd[gio_pkg::PIDX_D];
        gio_pkg::OFS_DATA_G:  prdata_nxt[W-1:0] = port_rd[gio_pkg::PIDX_G];
        gio_pkg::OFS_DIR_A:   prdata_nxt[W-1:0] = dir_r[gio_pkg::PIDX_A];
        gio_pkg::OFS_DIR_B:   prdata_nxt[W-1:0] = dir_r[gio_pkg::PIDX_B];
        gio_pkg::OFS_DIR_C:   prdata_nxt[W-1:0] = dir_r[gio_pkg::PIDX_C];
        gio_pkg::OFS_DIR_D:   prdata_nxt[W-1:0] = dir_r[gio_pkg::PIDX_D];
        gio_pkg::OFS_DIR_G:   prdata_nxt[W-1:0] = dir_r[gio_pkg::PIDX_G] & valid_m[gio_pkg::PIDX_G];
        gio_pkg::OFS_WAKE_EN: prdata_nxt[W-1:0] = wake_en_r;
        gio_pkg::OFS_HALT:    prdata_nxt[0]     = halt_r;
        gio_pkg::OFS_IRQ_ST:  prdata_nxt[gio_pkg::IRQ_W-1:0] = st_r;
        gio_pkg::OFS_IRQ_MSK: prdata_nxt[gio_pkg::IRQ_W-1:0] = msk_r;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_r      <= {N{gio_pkg::RST_PORT}};
      dir_r       <= {N{gio_pkg::RST_PORT}};
      wake_en_r   <= gio_pkg::RST_ZERO8;
      halt_r      <= 1'b0;
      st_r        <= '0;
      msk_r       <= '0;
      exti_prev_r <= 1'b1;
      prdata_r    <= gio_pkg::RD_ZERO;
    end else begin
      data_r      <= data_nxt;
      dir_r       <= dir_nxt;
      wake_en_r   <= wake_en_nxt;
      halt_r      <= halt_nxt;
      st_r        <= st_nxt;
      msk_r       <= msk_nxt;
      exti_prev_r <= exti_prev_nxt;
      prdata_r    <= prdata_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign halted = halt_r;
  assign irq    = |(st_r & msk_r);

endmodule

`default_nettype wire

// [dv/gio_top_asserts.sv]
/*
  Port checker for the GPIO block: pins, shared functions, wake, APB answer.
  Assumes binding onto gio_top, one clock, rst async active high.
*/
`timescale 1ns/1ps
`default_nettype none

module gio_top_asserts (
  input wire logic                    clk_sys,
  input wire logic                    rst,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [7:0]              paddr,
  input wire logic                    pready,
  input wire logic                    pslverr,
  input wire gio_pkg::gio_cfg_s       cfg,
  input wire logic [39:0]             pin_in,
  input wire gio_pkg::gio_pin_s [4:0] pins,
  input wire logic                    buzzer_out,
  input wire logic                    exti_en,
  input wire gio_pkg::gio_tmode_e     tmode0,
  input wire gio_pkg::gio_tmode_e     tmode1,
  input wire logic                    exti_n,
  input wire logic                    timer0_ext_input,
  input wire logic                    timer1_ext_input,
  input wire logic                    halted
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // ==========
  // Port A fall history, so a halt exit can be traced to a pin fall
  // ==========
  logic [7:0] pa_prev_r;     // Port A levels one edge back
  logic [7:0] pa_prev_nxt;
  logic [3:0] fall_hist_r;   // Falls seen over the last four edges
  logic [3:0] fall_hist_nxt;
  logic       fall_now;      // A one-to-zero step on any port A pin

  // Next-state of the history
  always_comb begin
    fall_now = |(pa_prev_r & ~pin_in[7:0]);
    pa_prev_nxt = pin_in[7:0];
    fall_hist_nxt = {fall_hist_r[2:0], fall_now};
  end

  // History registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pa_prev_r <= 8'hff;
      fall_hist_r <= 4'h0;
    end else begin
      pa_prev_r <= pa_prev_nxt;
      fall_hist_r <= fall_hist_nxt;
    end
  end

  // ==========
  // Sequences and properties
  // ==========
  sequence s_access;
    psel && penable;
  endsequence
  sequence s_pa_fall;
    fall_now || (fall_hist_r != 4'h0);
  endsequence
  property p_reset;
    @(posedge clk_sys) disable iff (1'b0)
    rst |-> pins[0].oe == 8'h00 && pins[3].oe == 8'h00 && !halted;
  endproperty

  a_ready_always: assert property (s_access |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (s_access ##0 paddr > 8'h38 |-> pslverr)
    else $error("no error on unmapped access");
  a_reset_inputs: assert property (p_reset)
    else $error("pins not inputs under reset");
  a_pull_inputs: assert property (1'b1 |->
    pins[0].pu == ({8{cfg.pull_en[0]}} & ~pins[0].oe) &&
    pins[3].pu == ({8{cfg.pull_en[3]}} & ~pins[3].oe))
    else $error("pull-high on an output or wrong port");
  a_latch_hold: assert property (!$past(psel && penable && pwrite) |->
    $stable(pins[0]) && $stable(pins[3]) && $stable(pins[4]))
    else $error("pins changed without a write");
  a_buzzer_drive: assert property (cfg.buzzer_en && pins[1].oe[1:0] == 2'b11 |->
    pins[1].o[0] == buzzer_out && pins[1].o[1] == !buzzer_out)
    else $error("buzzer not on port B outputs");
  a_exti_route: assert property (1'b1 |-> exti_n == (exti_en ? pin_in[32] : 1'b1))
    else $error("external interrupt routing wrong");
  a_timer_event: assert property ((tmode0 == gio_pkg::GIO_TM_EVENT ||
    tmode0 == gio_pkg::GIO_TM_PWM) && !pins[2].oe[0] |-> timer0_ext_input == pin_in[16])
    else $error("timer 0 input not fed from pin");
  a_timer_idle: assert property ((tmode1 == gio_pkg::GIO_TM_OFF ||
    tmode1 == gio_pkg::GIO_TM_TIMER) |-> !timer1_ext_input)
    else $error("timer 1 input active while idle");
  a_wake_cause: assert property ($fell(halted) |-> s_pa_fall)
    else $error("halt left without a port A fall");
endmodule

`default_nettype wire

// [dv/gio_pin_model.sv]
/*
  Model of the switches and wiring outside the pins.
  Assumes the testbench commands which pins are driven from outside.
*/
`timescale 1ns/1ps
`default_nettype none

module gio_pin_model (
  input  wire logic                    clk_sys,
  input  wire gio_pkg::gio_pin_s [4:0] pins,
  input  wire logic [39:0]             ext_en,
  input  wire logic [39:0]             ext_val,
  output logic [39:0]                  pin_in
);
  logic [39:0] float_r = 40'h55_5555_5555; // Floating pins never hold a level

  // Undriven and unpulled pins wander every cycle
  always_ff @(posedge clk_sys) begin
    float_r <= ~float_r;
  end

  // Wire level: own driver, then outside driver, then pull-high
  always_comb begin
    for (int i = 0; i < 40; i++) begin
      if (pins[i/8].oe[i%8]) begin
        pin_in[i] = pins[i/8].o[i%8];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];
      end else if (pins[i/8].pu[i%8]) begin
        pin_in[i] = 1'b1;
      end else begin
        pin_in[i] = float_r[i];
      end
    end
  end
endmodule

`default_nettype wire

// [dv/tb_gio_top.sv]
/*
  Self-checking bench for the GPIO block over APB.
  Assumes gio_pkg, gio_top, the pin model and the checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_gio_top;
  logic                    clk_sys, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata;
  logic [31:0]             rd;       // Last read data
  gio_pkg::gio_cfg_s       cfg;
  logic [39:0]             pin_in, ext_en, ext_val; // Levels; outside enable and value
  gio_pkg::gio_pin_s [4:0] pins;
  logic                    buzzer_out, exti_en, exti_n, halted, irq;
  logic                    timer0_ext_input, timer1_ext_input;
  gio_pkg::gio_tmode_e     tmode0, tmode1;
  logic                    err;      // Last slave error
  int                      fails, check_count;

  gio_top dut (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cfg, .pin_in, .pins, .buzzer_out, .exti_en, .tmode0, .tmode1,
    .exti_n, .timer0_ext_input, .timer1_ext_input, .halted, .irq);
  gio_pin_model u_pins (.clk_sys, .pins, .ext_en, .ext_val, .pin_in);

  // ==========
  // Clock and watchdog
  // ==========
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    give_verdict();
  end

  // ==========
  // Tasks
  // ==========
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    if (n >= 100) fails++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge clk_sys);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic endt(input string name);
    $display("test %s done", name);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ==========
  // Main sequence
  // ==========
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfg = '{pull_en: 5'b00101, buzzer_en: 1'b0};
    buzzer_out = 1'b0;
    exti_en = 1'b0;
    tmode0 = gio_pkg::GIO_TM_OFF;
    tmode1 = gio_pkg::GIO_TM_OFF;
    ext_en = 40'h01_ff21_00ff;
    ext_val = 40'h01_3c21_00ff;
    fails = 0;
    check_count = 0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset state: every direction all ones, pulled inputs read high
    for (int p = 0; p < 5; p++) begin
      rdchk(gio_pkg::OFS_DIR_A + 8'(4 * p), (p == 4) ? 32'h1 : 32'hff);
    end
    rdchk(gio_pkg::OFS_DATA_A, 32'hff);
    chk(32'(pins[0].pu), 32'hff);
    chk(32'(pins[1].pu), 32'h0);
    wr(gio_pkg::OFS_DIR_A, 32'h00);
    chk(32'(pins[0].pu), 32'h0);
    wr(gio_pkg::OFS_DIR_A, 32'hff);
    endt("reset");
    // Mixed directions on port D, then a bit clear by read-modify-write
    wr(gio_pkg::OFS_DATA_D, 32'ha5);
    wr(gio_pkg::OFS_DIR_D, 32'h0f);
    chk(32'(pins[3].oe), 32'hf0);
    chk(32'(pins[3].o), 32'ha5);
    rdchk(gio_pkg::OFS_DATA_D, 32'hac);
    ext_val[31:24] <= 8'hc3;
    rdchk(gio_pkg::OFS_DATA_D, 32'ha3);
    chk(32'(pins[3].o), 32'ha5);
    wr(gio_pkg::OFS_BITOP, 32'h037);
    rdchk(gio_pkg::OFS_DATA_D, 32'h23);
    wr(gio_pkg::OFS_DIR_D, 32'h00);
    chk(32'(pins[3].o), 32'h23);
    wr(gio_pkg::OFS_BITOP, 32'h1b7);
    rdchk(gio_pkg::OFS_DIR_D, 32'h80);
    endt("port_d");
    // Buzzer on port B outputs only
    cfg.buzzer_en <= 1'b1;
    buzzer_out <= 1'b1;
    wr(gio_pkg::OFS_DIR_B, 32'hfc);
    chk(32'(pins[1].o[1:0]), 32'h1);
    @(posedge clk_sys);
    buzzer_out <= 1'b0;
    @(posedge clk_sys);
    chk(32'(pins[1].o[1:0]), 32'h2);
    wr(gio_pkg::OFS_DIR_B, 32'hff);
    chk(32'(pins[1].oe[1:0]), 32'h0);
    endt("buzzer");
    // External interrupt fall, masked, unmasked, cleared
    exti_en <= 1'b1;
    ext_val[32] <= 1'b0;
    @(posedge clk_sys);
    chk(32'(exti_n), 32'h0);
    rdchk(gio_pkg::OFS_IRQ_ST, 32'h2);
    chk(32'(irq), 32'h0);
    wr(gio_pkg::OFS_IRQ_MSK, 32'h2);
    chk(32'(irq), 32'h1);
    wr(gio_pkg::OFS_IRQ_ST, 32'h2);
    chk(32'(irq), 32'h0);
    rdchk(gio_pkg::OFS_IRQ_ST, 32'h0);
    exti_en <= 1'b0;
    @(posedge clk_sys);
    chk(32'(exti_n), 32'h1);
    endt("exti");
    // Every timer mode on both shared pins, then an output pin
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_sys);
      tmode0 <= gio_pkg::gio_tmode_e'(m);
      tmode1 <= gio_pkg::gio_tmode_e'(m);
      @(posedge clk_sys);
      chk(32'(timer0_ext_input), 32'(m >= 2));
      chk(32'(timer1_ext_input), 32'(m >= 2));
    end
    wr(gio_pkg::OFS_DIR_C, 32'hfe);
    chk(32'(timer0_ext_input), 32'h0);
    endt("timer");
    // Wake from halt: a fall on a disabled pin is ignored
    wr(gio_pkg::OFS_WAKE_EN, 32'h04);
    wr(gio_pkg::OFS_HALT, 32'h1);
    rdchk(gio_pkg::OFS_HALT, 32'h1);
    ext_val[1] <= 1'b0;
    repeat (5) @(posedge clk_sys);
    rdchk(gio_pkg::OFS_HALT, 32'h1);
    rdchk(gio_pkg::OFS_IRQ_ST, 32'h0);
    ext_val[2] <= 1'b0;
    for (int i = 0; i < 10 && halted !== 1'b0; i++) @(posedge clk_sys);
    @(posedge clk_sys);
    chk(32'(halted), 32'h0);
    rdchk(gio_pkg::OFS_IRQ_ST, 32'h1);
    endt("wake");
    // Unmapped place
    rdchk(8'h3c, 32'h0);
    chk(32'(err), 32'h1);
    endt("unmapped");
    give_verdict();
  end
endmodule

bind gio_top gio_top_asserts u_chk (.clk_sys, .rst, .psel, .penable, .pwrite, .paddr,
  .pready, .pslverr, .cfg, .pin_in, .pins, .buzzer_out, .exti_en, .tmode0, .tmode1,
  .exti_n, .timer0_ext_input, .timer1_ext_input, .halted);

`default_nettype wire
